// *** rtl/fault_sup_pkg.sv ***
package fault_sup_pkg;
  localparam int DATA_W = 16;
  localparam int N_IN   = 4;
  localparam int N_OUT  = 4;

  // Register offsets (word addresses)
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_STATUS    = 4'h1;
  localparam logic [3:0] ADDR_SCALE_LO  = 4'h2;
  localparam logic [3:0] ADDR_SCALE_HI  = 4'h3;
  localparam logic [3:0] ADDR_RATIO     = 4'h4;
  localparam logic [3:0] ADDR_CFG       = 4'h5;
  localparam logic [3:0] ADDR_HOLD_VAL  = 4'h6;
  localparam logic [3:0] ADDR_UNIT_NO   = 4'h7;

  // CTRL bits
  localparam int CTRL_RESTART   = 0;
  localparam int CTRL_SCALE_EN  = 1;
  localparam int CTRL_RATIO_EN  = 2;

  // CFG field positions
  localparam int CFG_AVG_LSB    = 0;
  localparam int CFG_NIN_LSB    = 3;
  localparam int CFG_IRANGE_LSB = 6;
  localparam int CFG_NOUT_LSB   = 8;
  localparam int CFG_ORANGE_LSB = 11;
  localparam int CFG_RES_LSB    = 13;
  localparam int CFG_OPMODE_LSB = 14;
  localparam int CFG_SCHEME_LSB = 15;
  localparam int CFG_HOLD_LSB   = 16;
  localparam int CFG_RATIO_CH   = 18;

  // Limits and reset values
  localparam logic [15:0] SCALE_MAX   = 16'h7FFF;
  localparam logic [15:0] RATIO_MAX   = 16'h270F;
  localparam logic [6:0]  UNIT_NO_MAX = 7'h5F;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [6:0]  UNIT_NO_RESET = 7'h00;
  localparam logic [15:0] ZERO_DATA   = 16'h0000;
  localparam int RESTART_NS = 1000;
  localparam int CLK_NS     = 40;
  localparam int RESTART_CYC = (RESTART_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] RESTART_LOAD = 8'(RESTART_CYC);

  typedef enum logic [1:0] {HOLD_CLEAR, HOLD_LAST, HOLD_MAX} hold_mode_t;
  typedef enum {ST_RESTART, ST_RUN, ST_STOPPED} run_state_t;
endpackage

// *** rtl/io_unit_fault_supervisor.sv ***
`timescale 1ns/1ns
// Overview of operation
// - Setting error blocks conversion, zeroes data
// - Setting flags clear only after fixed restart
// - Scaling error: limit too big or equal nonzero
// - Ratio error when selected channel unused
// - Ratio value out of range flags error
// - Bad averaging sample count flags error
// - Bad input count or range flags error
// - Bad output count or range flags error
// - Resolution and operating mode bits both set flags error
// - Non-cyclic conversion scheme flags error
// - Bus transfer error: zero inputs, hold outputs
// - Host timeout: keep inputs and outputs
// - Host watchdog fault: outputs to hold value
// - Bad unit number: no conversion, zeroes
// - Configuration mismatch: no conversion, zeroes
// - Restart on rising restart request bit
// - New settings take effect only at restart
// - During restart, zero inputs and outputs
// - Run-time alarms self-clear when cause ends
module io_unit_fault_supervisor
(
  input  wire logic                              ref_clk,
  input  wire logic                              rst_n,
  input  wire logic [3:0]                        addr,
  input  wire logic [31:0]                       wdata,
  input  wire logic                              wr_stb,
  input  wire logic                              rd_stb,
  output logic [31:0]                            rdata,
  input  wire logic                              bus_xfer_err,
  input  wire logic                              host_timeout,
  input  wire logic                              host_wdt_err,
  input  wire logic                              unit_no_dup,
  input  wire logic                              config_mismatch,
  input  wire logic                              out_range_alarm,
  input  wire logic                              disconnect_alarm,
  input  wire logic [fault_sup_pkg::DATA_W-1:0]  conv_in,
  input  wire logic [fault_sup_pkg::DATA_W-1:0]  out_set,
  output logic [fault_sup_pkg::DATA_W-1:0]       conv_data,
  output logic [fault_sup_pkg::DATA_W-1:0]       analog_out,
  output logic                                   converting,
  output logic                                   unit_alarm_indicator,
  output logic                                   host_fault_indicator
);
  import fault_sup_pkg::*;

  logic [31:0]       ctrl_reg;
  logic [31:0]       cfg_reg;
  logic [15:0]       scale_lo_reg;
  logic [15:0]       scale_hi_reg;
  logic [15:0]       ratio_reg;
  logic [15:0]       hold_val_reg;
  logic [6:0]        unit_no_reg;
  // Active copies, loaded only at restart
  logic [31:0]       act_ctrl_reg;
  logic [31:0]       act_cfg_reg;
  logic [15:0]       act_lo_reg;
  logic [15:0]       act_hi_reg;
  logic [15:0]       act_ratio_reg;
  logic [15:0]       act_hold_reg;
  logic [6:0]        act_unit_reg;
  logic              restart_d_reg;
  logic [7:0]        restart_cnt_reg;
  run_state_t        state_reg;
  logic [7:0]        err_flags_reg;
  logic [7:0]        err_next;
  logic              rd_pending_reg;
  logic [3:0]        rd_addr_reg;
  logic              alarm_reg;
  logic              restart_pulse;
  logic              unit_bad;
  logic              stop_req;
  logic              restart_done;
  logic              flag_load;
  logic [31:0]       status_word;

  function automatic logic in_set3(input logic [2:0] v);
    return (v == 3'h0) || (v == 3'h1) || (v == 3'h2) || (v == 3'h3) || (v == 3'h4);
  endfunction

  function automatic logic count_ok(input logic [2:0] v, input int maxn);
    return (v != 3'h0) && (int'(v) <= maxn);
  endfunction

  function automatic logic wr_hit(input logic stb, input logic [3:0] a_bus, input logic [3:0] a_reg);
    return stb && (a_bus == a_reg);
  endfunction

  function automatic logic scale_bad(input logic [15:0] lo, input logic [15:0] hi);
    // Equal limits are only an error when nonzero
    return (lo > SCALE_MAX) || (hi > SCALE_MAX) || ((lo == hi) && (lo != ZERO_DATA));
  endfunction

  function automatic logic range_bad(input logic [1:0] sel);
    return sel == 2'h3;
  endfunction

  assign restart_pulse = ctrl_reg[CTRL_RESTART] && !restart_d_reg;
  assign unit_bad = (act_unit_reg > UNIT_NO_MAX) || unit_no_dup;
  assign stop_req = (err_flags_reg != 8'h00) || unit_bad || config_mismatch;
  assign restart_done = (state_reg == ST_RESTART) && (restart_cnt_reg == 8'h00);
  assign flag_load = (state_reg == ST_RESTART) && (restart_cnt_reg == 8'h01);

  // Software-visible settings, one register per process
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_hit(wr_stb, addr, ADDR_CTRL)) begin
      ctrl_reg <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= CFG_RESET;
    end else if (wr_hit(wr_stb, addr, ADDR_CFG)) begin
      cfg_reg <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scale_lo_reg <= ZERO_DATA;
    end else if (wr_hit(wr_stb, addr, ADDR_SCALE_LO)) begin
      scale_lo_reg <= wdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scale_hi_reg <= ZERO_DATA;
    end else if (wr_hit(wr_stb, addr, ADDR_SCALE_HI)) begin
      scale_hi_reg <= wdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ratio_reg <= ZERO_DATA;
    end else if (wr_hit(wr_stb, addr, ADDR_RATIO)) begin
      ratio_reg <= wdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_val_reg <= ZERO_DATA;
    end else if (wr_hit(wr_stb, addr, ADDR_HOLD_VAL)) begin
      hold_val_reg <= wdata[15:0];
    end
  end

  // Upper unit number bits dropped; range check sees the 7-bit value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_no_reg <= UNIT_NO_RESET;
    end else if (wr_hit(wr_stb, addr, ADDR_UNIT_NO)) begin
      unit_no_reg <= wdata[6:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_d_reg <= 1'b0;
    end else begin
      restart_d_reg <= ctrl_reg[CTRL_RESTART];
    end
  end

  // Settings latched into active copies at restart only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_ctrl_reg  <= 32'h0000_0000;
      act_cfg_reg   <= CFG_RESET;
      act_lo_reg    <= ZERO_DATA;
      act_hi_reg    <= ZERO_DATA;
      act_ratio_reg <= ZERO_DATA;
      act_hold_reg  <= ZERO_DATA;
      act_unit_reg  <= 7'h00;
    end else if (restart_pulse) begin
      act_ctrl_reg  <= ctrl_reg;
      act_cfg_reg   <= cfg_reg;
      act_lo_reg    <= scale_lo_reg;
      act_hi_reg    <= scale_hi_reg;
      act_ratio_reg <= ratio_reg;
      act_hold_reg  <= hold_val_reg;
      act_unit_reg  <= unit_no_reg;
    end
  end

  // Validation of the setting snapshot
  always_comb begin
    err_next = 8'h00;
    if (act_ctrl_reg[CTRL_SCALE_EN]) begin
      err_next[0] = scale_bad(act_lo_reg, act_hi_reg);
    end
    if (act_ctrl_reg[CTRL_RATIO_EN]) begin
      err_next[1] = (int'(act_cfg_reg[CFG_RATIO_CH +: 2]) >=
                     int'(act_cfg_reg[CFG_NIN_LSB +: 3]));
      err_next[2] = act_ratio_reg > RATIO_MAX;
    end
    err_next[3] = !in_set3(act_cfg_reg[CFG_AVG_LSB +: 3]);
    err_next[4] = !count_ok(act_cfg_reg[CFG_NIN_LSB +: 3], N_IN) ||
                  range_bad(act_cfg_reg[CFG_IRANGE_LSB +: 2]);
    err_next[5] = !count_ok(act_cfg_reg[CFG_NOUT_LSB +: 3], N_OUT) ||
                  range_bad(act_cfg_reg[CFG_ORANGE_LSB +: 2]);
    err_next[6] = act_cfg_reg[CFG_RES_LSB] && act_cfg_reg[CFG_OPMODE_LSB];
    err_next[6] = err_next[6] || act_cfg_reg[CFG_SCHEME_LSB];
    err_next[7] = range_bad(act_cfg_reg[CFG_HOLD_LSB +: 2]);
  end

  // Flags only re-evaluated at the end of a restart
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_flags_reg <= 8'h00;
    end else if (flag_load) begin
      err_flags_reg <= err_next;
    end
  end

  // Restart countdown; runs only while restarting
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_cnt_reg <= RESTART_LOAD;
    end else if (restart_pulse) begin
      restart_cnt_reg <= RESTART_LOAD;
    end else if (state_reg == ST_RESTART && restart_cnt_reg != 8'h00) begin
      restart_cnt_reg <= restart_cnt_reg - 8'h01;
    end
  end

  // A faulty setup never enters RUN, not even for one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RESTART;
    end else if (restart_pulse) begin
      state_reg <= ST_RESTART;
    end else begin
      unique case (state_reg)
        ST_RESTART: begin
          if (restart_done && stop_req) begin
            state_reg <= ST_STOPPED;
          end else if (restart_done) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stop_req) begin
            state_reg <= ST_STOPPED;
          end
        end
        ST_STOPPED: ;
      endcase
    end
  end

  // Input data; fault priority is transfer error, watchdog, timeout
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_data <= ZERO_DATA;
    end else if (state_reg != ST_RUN) begin
      conv_data <= ZERO_DATA;
    end else if (bus_xfer_err) begin
      conv_data <= ZERO_DATA;
    end else if (host_wdt_err) begin
      conv_data <= conv_in; // Undefined allowed; pass-through is cheapest
    end else if (!host_timeout) begin
      conv_data <= disconnect_alarm ? ZERO_DATA : conv_in;
    end // Timeout: value kept
  end

  // Output data, same priority as the input side
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_out <= ZERO_DATA;
    end else if (state_reg != ST_RUN) begin
      analog_out <= ZERO_DATA;
    end else if (bus_xfer_err || host_wdt_err) begin
      analog_out <= act_hold_reg;
    end else if (!host_timeout) begin
      analog_out <= out_range_alarm ? act_hold_reg : out_set;
    end // Timeout: level kept
  end

  assign converting = (state_reg == ST_RUN);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= 1'b0;
    end else begin
      alarm_reg <= out_range_alarm || disconnect_alarm;
    end
  end

  assign unit_alarm_indicator = (err_flags_reg != 8'h00) || alarm_reg;
  assign host_fault_indicator = bus_xfer_err || host_timeout || host_wdt_err ||
                                unit_bad || config_mismatch;

  // Read port, data in the following cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pending_reg <= 1'b0;
    end else begin
      rd_pending_reg <= rd_stb;
    end
  end

  // Address taken every cycle; only rd_pending_reg qualifies it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_reg <= 4'h0;
    end else begin
      rd_addr_reg <= addr;
    end
  end

  // Flags, state, run flag, unit fault and run alarm
  assign status_word = {19'h0, alarm_reg, unit_bad, converting, 2'(state_reg), err_flags_reg};

  always_comb begin
    rdata = 32'h0000_0000;
    if (rd_pending_reg) begin
      unique case (rd_addr_reg)
        ADDR_CTRL:     rdata = ctrl_reg;
        ADDR_STATUS:   rdata = status_word;
        ADDR_SCALE_LO: rdata = {16'h0000, scale_lo_reg};
        ADDR_SCALE_HI: rdata = {16'h0000, scale_hi_reg};
        ADDR_RATIO:    rdata = {16'h0000, ratio_reg};
        ADDR_CFG:      rdata = cfg_reg;
        ADDR_HOLD_VAL: rdata = {16'h0000, hold_val_reg};
        ADDR_UNIT_NO:  rdata = {25'h0, unit_no_reg};
        default:       rdata = 32'h0000_0000;
      endcase
    end
  end
endmodule

// *** verification/fault_sup_checker.sv ***
`timescale 1ns/1ns
module fault_sup_checker
  import fault_sup_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic [3:0]        addr,
  input wire logic [31:0]       wdata,
  input wire logic              wr_stb,
  input wire logic              rd_stb,
  input wire logic [31:0]       rdata,
  input wire logic              bus_xfer_err,
  input wire logic              host_timeout,
  input wire logic              host_wdt_err,
  input wire logic              unit_no_dup,
  input wire logic              config_mismatch,
  input wire logic              out_range_alarm,
  input wire logic [DATA_W-1:0] conv_data,
  input wire logic [DATA_W-1:0] analog_out,
  input wire logic              converting,
  input wire logic              unit_alarm_indicator,
  input wire logic              host_fault_indicator
);
  logic ctrl_b0_reg;
  logic restart_req;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Only a 0 to 1 step of the bit restarts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_b0_reg <= 1'b0;
    end else if (wr_stb && addr == ADDR_CTRL) begin
      ctrl_b0_reg <= wdata[CTRL_RESTART];
    end
  end
  assign restart_req = wr_stb && addr == ADDR_CTRL && wdata[CTRL_RESTART] && !ctrl_b0_reg;
  idle_zero_a: assert property (!converting && !$past(converting) |-> conv_data == ZERO_DATA)
    else $error("conversion data not zero while stopped");
  xfer_zero_a: assert property (bus_xfer_err |=> conv_data == ZERO_DATA)
    else $error("conversion data not zero on transfer error");
  timeout_hold_a: assert property
    (host_timeout && converting && !bus_xfer_err && !host_wdt_err |=> $stable(conv_data) && $stable(analog_out))
    else $error("data changed during host timeout");
  dup_stop_a: assert property (unit_no_dup ##1 unit_no_dup |=> !converting && analog_out == ZERO_DATA)
    else $error("unit still running with bad unit number");
  cfg_stop_a: assert property (config_mismatch ##1 config_mismatch |=> !converting && conv_data == ZERO_DATA)
    else $error("unit still running with configuration mismatch");
  restart_a: assert property (restart_req |-> ##[1:4] !converting)
    else $error("no restart after request bit rose");
  alarm_on_a: assert property (out_range_alarm ##1 out_range_alarm |-> unit_alarm_indicator)
    else $error("alarm indicator off during run alarm");
  host_ind_a: assert property (bus_xfer_err || unit_no_dup || config_mismatch |-> host_fault_indicator)
    else $error("host fault indicator off during host fault");
  unmapped_a: assert property (rd_stb && addr > ADDR_UNIT_NO |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  cover property (restart_req);
  cover property (host_timeout);
  cover property (bus_xfer_err);
  cover property (host_wdt_err && converting);
endmodule
bind io_unit_fault_supervisor fault_sup_checker i_fault_sup_checker (.ref_clk, .rst_n, .addr, .wdata, .wr_stb,
  .rd_stb, .rdata, .bus_xfer_err, .host_timeout, .host_wdt_err, .unit_no_dup, .config_mismatch, .out_range_alarm,
  .conv_data, .analog_out, .converting, .unit_alarm_indicator, .host_fault_indicator);

// *** verification/host_cpu_model.sv ***
`timescale 1ns/1ns
module host_cpu_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] fault_cmd,
  output logic            bus_xfer_err,
  output logic            host_timeout,
  output logic            host_wdt_err,
  output logic            unit_no_dup,
  output logic            config_mismatch
);
  logic [4:0] lvl_reg;
  // Fault levels change only on the host clock edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_reg <= 5'h00;
    end else begin
      lvl_reg <= fault_cmd;
    end
  end
  assign {config_mismatch, unit_no_dup, host_wdt_err, host_timeout, bus_xfer_err} = lvl_reg;
endmodule

// *** verification/tb_io_unit_fault_supervisor.sv ***
`timescale 1ns/1ns
module tb_io_unit_fault_supervisor;
  import fault_sup_pkg::*;
  localparam logic [31:0] GOOD = 32'h0000_0420;
  localparam logic [31:0] B_CFG [9] = '{GOOD, GOOD, 32'h000C_0410, 32'h0000_0427, 32'h0000_04E0,
    32'h0000_1C20, 32'h0000_6420, 32'h0000_8420, 32'h0003_0420};
  localparam logic [31:0] B_CTL [9] = '{32'h2, 32'h4, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam logic [3:0]  B_ADR [9] = '{ADDR_SCALE_HI, ADDR_RATIO, ADDR_RATIO, ADDR_HOLD_VAL, ADDR_HOLD_VAL,
    ADDR_HOLD_VAL, ADDR_HOLD_VAL, ADDR_HOLD_VAL, ADDR_HOLD_VAL};
  localparam logic [31:0] B_VAL [9] = '{32'h8000, 32'h2710, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam int          B_BIT [9] = '{0, 2, 1, 3, 4, 5, 6, 6, 7};
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [3:0]        addr = 4'h0;
  logic [31:0]       wdata = 32'h0;
  logic              wr_stb = 1'b0;
  logic              rd_stb = 1'b0;
  logic [31:0]       rdata, d;
  logic [4:0]        cmd = 5'h00;
  logic              out_range_alarm = 1'b0;
  logic [DATA_W-1:0] conv_in = 16'h1234;
  logic [DATA_W-1:0] conv_data, analog_out;
  logic              bus_xfer_err, host_timeout, host_wdt_err, unit_no_dup, config_mismatch;
  logic              converting, unit_alarm_indicator, host_fault_indicator;
  int                err_total = 0;
  int                compares = 0;
  always #20 ref_clk = ~ref_clk;
  host_cpu_model i_host_cpu_model (.ref_clk, .rst_n, .fault_cmd(cmd), .bus_xfer_err, .host_timeout,
    .host_wdt_err, .unit_no_dup, .config_mismatch);
  io_unit_fault_supervisor i_io_unit_fault_supervisor (.ref_clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .bus_xfer_err, .host_timeout, .host_wdt_err, .unit_no_dup, .config_mismatch, .out_range_alarm,
    .disconnect_alarm(out_range_alarm), .conv_in, .out_set(16'h0567), .conv_data, .analog_out, .converting,
    .unit_alarm_indicator, .host_fault_indicator);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Keeps enable bits set while pulsing the restart bit
  task automatic restart(input logic [31:0] en);
    wr(ADDR_CTRL, en | 32'h1);
    cyc(3);
    chk("restart_io", {conv_data, analog_out}, 32'h0);
    wr(ADDR_CTRL, en);
    cyc(RESTART_CYC + 4);
  endtask
  task automatic end_sim;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(ADDR_CFG, GOOD);
    restart(32'h0);
    chk("conv", conv_data, 32'h1234);
    wr(ADDR_CFG, 32'h0000_0427);
    rd(ADDR_STATUS);
    chk("stale_flags", d[7:0], 32'h0);
    for (int i = 0; i < 9; i++) begin
      wr(ADDR_CFG, B_CFG[i]);
      wr(B_ADR[i], B_VAL[i]);
      restart(B_CTL[i]);
      rd(ADDR_STATUS);
      chk("flags", d[7:0], 32'h1 << B_BIT[i]);
      chk("stop_conv", {converting, conv_data}, 32'h0);
    end
    wr(ADDR_CFG, GOOD);
    rd(ADDR_STATUS);
    chk("held_flag", d[7:0], 32'h80);
    wr(ADDR_HOLD_VAL, 32'h0000_00AB);
    restart(32'h0);
    rd(ADDR_STATUS);
    chk("clear_flag", d[7:0], 32'h0);
    chk("out_run", analog_out, 32'h0567);
    cmd <= 5'h02;
    cyc(2);
    conv_in <= 16'h4321;
    cyc(3);
    chk("timeout_hold", {conv_data, analog_out}, 32'h1234_0567);
    cmd <= 5'h00;
    cyc(3);
    chk("after_timeout", conv_data, 32'h4321);
    out_range_alarm <= 1'b1;
    cyc(3);
    chk("alarm_on", unit_alarm_indicator, 32'h1);
    chk("alarm_hold", analog_out, 32'h00AB);
    out_range_alarm <= 1'b0;
    cyc(3);
    chk("alarm_off", unit_alarm_indicator, 32'h0);
    chk("alarm_release", analog_out, 32'h0567);
    cmd <= 5'h01;
    cyc(3);
    chk("xfer_zero", {host_fault_indicator, conv_data}, 32'h1_0000);
    chk("xfer_hold", analog_out, 32'h00AB);
    cmd <= 5'h04;
    cyc(3);
    chk("wdt_hold", {host_fault_indicator, analog_out}, 32'h1_00AB);
    for (int k = 3; k < 5; k++) begin
      cmd <= 5'h1 << k;
      cyc(4);
      chk("unit_stop", {converting, conv_data, analog_out}, 32'h0);
      cmd <= 5'h00;
      restart(32'h0);
      chk("rerun", converting, 32'h1);
    end
    wr(ADDR_UNIT_NO, 32'h0000_0060);
    restart(32'h0);
    chk("unit_range", {converting, analog_out}, 32'h0);
    wr(ADDR_UNIT_NO, 32'h0000_005F);
    restart(32'h0);
    chk("unit_max", converting, 32'h1);
    rd(4'hF);
    chk("unmapped", d, 32'h0);
    end_sim;
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    err_total++;
    end_sim;
  end
endmodule
